// ===== common/radar_acq_pkg.sv
// radar_acq_pkg: constants, register map and state types of the baseband capture block
// assumes one 250 MHz clock and a plain strobe-based register port
package radar_acq_pkg;

    // ----------------------------------------------------------------
    // data path
    // ----------------------------------------------------------------
    localparam int          SAMPLE_WIDTH   = 12;               // converter result width
    localparam int          ITEM_WIDTH     = 16;               // two bytes per item
    localparam int          NUM_CHANNELS   = 4;
    localparam int          BLOCK_ITEMS    = 250;              // items per block
    localparam int          ADDR_WIDTH     = 16;               // memory word address width
    localparam logic [7:0]  BLOCK_ITEMS_W  = 8'(BLOCK_ITEMS);

    // channel order: quadrature high, inphase high, quadrature low, inphase low
    localparam logic [1:0]  CH_QUADRATURE_HIGH_GAIN = 2'h0;
    localparam logic [1:0]  CH_INPHASE_HIGH_GAIN    = 2'h1;
    localparam logic [1:0]  CH_QUADRATURE_LOW_GAIN  = 2'h2;
    localparam logic [1:0]  CH_INPHASE_LOW_GAIN     = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLOCK_PERIOD_PS  = 4000;
    localparam int          SAMPLE_WINDOW_PS = 75000;          // 75 ns sampling window
    // least time, rounded up to whole cycles
    localparam int          SAMPLE_WINDOW_CYC = (SAMPLE_WINDOW_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

    // ----------------------------------------------------------------
    // register map (word offsets as byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CONTROL      = 8'h00;
    localparam logic [7:0]  REG_STATUS       = 8'h04;
    localparam logic [7:0]  REG_FRAME_PERIOD = 8'h08;
    localparam logic [7:0]  REG_SAMPLE_PERIOD = 8'h0C;
    localparam logic [7:0]  REG_BASE_0       = 8'h10;          // base of channel n at 0x10 + 4*n
    localparam logic [7:0]  REG_COUNT_0      = 8'h20;          // item count of channel n at 0x20 + 4*n

    // control fields
    localparam int          CTL_RUN_BIT      = 0;
    localparam int          CTL_XCVR_BIT     = 1;
    localparam int          CTL_DIV_BIT      = 2;
    localparam int          CTL_TX_BIT       = 3;
    localparam int          CTL_PTAT_BIT     = 4;
    localparam int          CTL_WIDTH        = 5;
    localparam logic [4:0]  CTL_RESET        = 5'h00;

    // status fields
    localparam int          STS_BUSY_BIT     = 0;
    localparam int          STS_DONE_BIT     = 1;

    localparam logic [31:0] FRAME_PERIOD_RESET  = 32'h0000_1000;
    localparam logic [15:0] SAMPLE_PERIOD_RESET = 16'h0040;
    localparam logic [15:0] BASE_RESET          = 16'h0000;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_WAIT_FRAME,
        ACQ_RUN
    } acq_state_e;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_SAMPLE,
        CONV_DONE
    } conv_state_e;

endpackage : radar_acq_pkg

// ===== rtl/baseband_converter_ctrl.sv
// baseband_converter_ctrl: sequences one sampling pass over the four baseband channels
// assumes the analog front end delivers 12-bit results that are settled after the window
`timescale 1ns/1ps

module baseband_converter_ctrl
    import radar_acq_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    trigger_i,
    input  wire logic [SAMPLE_WIDTH-1:0] inphase_high_gain_i,
    input  wire logic [SAMPLE_WIDTH-1:0] quadrature_high_gain_i,
    input  wire logic [SAMPLE_WIDTH-1:0] inphase_low_gain_i,
    input  wire logic [SAMPLE_WIDTH-1:0] quadrature_low_gain_i,
    output logic                         request_o,
    output logic [4*ITEM_WIDTH-1:0]      items_o
);

    typedef struct packed {
        conv_state_e          state;
        logic [4:0]           window;
        logic                 request;
        logic [4*ITEM_WIDTH-1:0] items;
    } conv_s;

    conv_s cur;
    conv_s next_cur;

    // zero-extend a 12-bit result into a two-byte item
    function automatic logic [ITEM_WIDTH-1:0] to_item(input logic [SAMPLE_WIDTH-1:0] s);
        to_item = {{(ITEM_WIDTH-SAMPLE_WIDTH){1'b0}}, s};
    endfunction : to_item

    // ----------------------------------------------------------------
    // sampling sequence
    // ----------------------------------------------------------------
    always_comb begin
        next_cur         = cur;
        next_cur.request = 1'b0;
        case (cur.state)
            CONV_IDLE: begin
                if (trigger_i) begin
                    next_cur.state  = CONV_SAMPLE;
                    next_cur.window = 5'(SAMPLE_WINDOW_CYC - 1);
                end
            end
            CONV_SAMPLE: begin
                // hold the sampling window open for 75 ns
                if (cur.window == 5'd0) begin
                    next_cur.state = CONV_DONE;
                end else begin
                    next_cur.window = cur.window - 5'd1;
                end
            end
            CONV_DONE: begin
                // 12-bit results, two bytes per channel, q-high first
                next_cur.items   = {to_item(inphase_low_gain_i), to_item(quadrature_low_gain_i),
                                    to_item(inphase_high_gain_i), to_item(quadrature_high_gain_i)};
                next_cur.request = 1'b1;       // one request paces one item per channel
                next_cur.state   = CONV_IDLE;
            end
            default: begin
                next_cur.state = CONV_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cur <= '{state: CONV_IDLE, window: 5'd0, request: 1'b0, items: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign request_o = cur.request;
    assign items_o   = cur.items;

endmodule : baseband_converter_ctrl

// ===== rtl/radar_baseband_acquisition.sv
// radar_baseband_acquisition: frame timer, sample pacing, four capture channels and supply enables
// assumes analog inputs are held stable through a window and memory accepts one write per cycle
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - converter delivers 12-bit results per sample
// - four channels, two bytes per sample
// - sampling window lasts 75 nanoseconds
// - four independent capture channels, one per stream
// - single block per channel, engine ends block
// - 250 items of 16 bits, request-paced
// - output switches divider supply
// - output enables transmit power
// - output supplies temperature reference
// - frame timer starts pulses and sampling together
// - pulse-width signal triggers equally spaced samples
// - after last sample, channels disable, pulses stop
module radar_baseband_acquisition
    import radar_acq_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // register port
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic [31:0]             reg_wdata_i,
    input  wire logic                    reg_write_i,
    input  wire logic                    reg_read_i,
    output logic [31:0]                  reg_rdata_o,
    // baseband converter inputs
    input  wire logic [SAMPLE_WIDTH-1:0] inphase_high_gain_i,
    input  wire logic [SAMPLE_WIDTH-1:0] quadrature_high_gain_i,
    input  wire logic [SAMPLE_WIDTH-1:0] inphase_low_gain_i,
    input  wire logic [SAMPLE_WIDTH-1:0] quadrature_low_gain_i,
    // memory write port
    output logic                         mem_write_o,
    output logic [1:0]                   mem_channel_o,
    output logic [ADDR_WIDTH-1:0]        mem_addr_o,
    output logic [ITEM_WIDTH-1:0]        mem_data_o,
    // transceiver control
    output logic                         pulse_o,
    output logic                         transceiver_supply_en_o,
    output logic                         divider_supply_en_o,
    output logic                         transmit_power_en_o,
    output logic                         temp_reference_supply_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        acq_state_e                      state;
        logic [CTL_WIDTH-1:0]            control;
        logic                            done;
        logic [31:0]                     frame_period;
        logic [31:0]                     frame_count;
        logic [15:0]                     sample_period;
        logic [15:0]                     pulse_count;
        logic                            pulse;
        logic [NUM_CHANNELS-1:0]         chan_enable;
        logic [NUM_CHANNELS*ADDR_WIDTH-1:0] base;
        logic [NUM_CHANNELS*8-1:0]       count;
        logic [NUM_CHANNELS*ITEM_WIDTH-1:0] pending;
        logic [NUM_CHANNELS-1:0]         pending_valid;
        logic                            mem_write;
        logic [1:0]                      mem_channel;
        logic [ADDR_WIDTH-1:0]           mem_addr;
        logic [ITEM_WIDTH-1:0]           mem_data;
        logic [31:0]                     rdata;
    } acq_s;

    acq_s cur;
    acq_s next_cur;

    logic                            conv_request;
    logic [NUM_CHANNELS*ITEM_WIDTH-1:0] conv_items;
    logic                            sample_trigger;

    // register index decode, used by both read and write
    function automatic logic [1:0] reg_chan(input logic [7:0] addr);
        reg_chan = addr[3:2];
    endfunction : reg_chan

    // ----------------------------------------------------------------
    // converter sequencer
    // ----------------------------------------------------------------
    // one sampling pass per rising pulse edge, all four streams together
    baseband_converter_ctrl u_converter (
        .clock_i                (clock_i),
        .rst_n_i                (rst_n_i),
        .trigger_i              (sample_trigger),
        .inphase_high_gain_i    (inphase_high_gain_i),
        .quadrature_high_gain_i (quadrature_high_gain_i),
        .inphase_low_gain_i     (inphase_low_gain_i),
        .quadrature_low_gain_i  (quadrature_low_gain_i),
        .request_o              (conv_request),
        .items_o                (conv_items)
    );

    // sampling starts on each rising edge of the pacing pulse
    assign sample_trigger = (cur.state == ACQ_RUN) && (cur.pulse_count == 16'd0) && !cur.pulse;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0]  ch;
        logic        served;
        ch               = 2'd0;
        served           = 1'b0;
        next_cur         = cur;
        next_cur.mem_write = 1'b0;
        next_cur.rdata   = 32'h0000_0000;

        // frame timer, free running while run is set
        if (cur.control[CTL_RUN_BIT]) begin
            if (cur.frame_count == 32'd0) begin
                next_cur.frame_count = cur.frame_period;
            end else begin
                next_cur.frame_count = cur.frame_count - 32'd1;
            end
        end else begin
            next_cur.frame_count = 32'd0;
        end

        case (cur.state)
            ACQ_IDLE: begin
                if (cur.control[CTL_RUN_BIT]) begin
                    next_cur.state = ACQ_WAIT_FRAME;
                end
            end
            ACQ_WAIT_FRAME: begin
                if (!cur.control[CTL_RUN_BIT]) begin
                    next_cur.state = ACQ_IDLE;
                end else if (cur.frame_count == 32'd0) begin
                    // frame start arms pulses and all channels at once
                    next_cur.state         = ACQ_RUN;
                    next_cur.chan_enable   = '1;
                    next_cur.count         = '0;
                    next_cur.pending_valid = '0;
                    next_cur.pulse_count   = 16'd0;
                    next_cur.pulse         = 1'b0;
                    next_cur.done          = 1'b0;
                end
            end
            ACQ_RUN: begin
                // pulse-width pacing signal, period set by software
                if (cur.pulse_count == 16'd0) begin
                    next_cur.pulse_count = cur.sample_period;
                    next_cur.pulse       = !cur.pulse;
                end else begin
                    next_cur.pulse_count = cur.pulse_count - 16'd1;
                end
                // block complete: disable channels, stop pulses and sampling
                if (cur.chan_enable == '0 && cur.pending_valid == '0) begin
                    next_cur.state = ACQ_WAIT_FRAME;
                    next_cur.pulse = 1'b0;
                    next_cur.done  = 1'b1;
                end
            end
            default: begin
                next_cur.state = ACQ_IDLE;
            end
        endcase

        // each converter request carries one item per channel
        if (conv_request) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (cur.chan_enable[i]) begin
                    next_cur.pending[i*ITEM_WIDTH +: ITEM_WIDTH] = conv_items[i*ITEM_WIDTH +: ITEM_WIDTH];
                    next_cur.pending_valid[i] = 1'b1;
                end
            end
        end

        // drain one pending item per cycle, lowest channel first
        for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
            if (cur.pending_valid[i]) begin
                ch     = 2'(i);
                served = 1'b1;
            end
        end
        if (served) begin
            next_cur.pending_valid[ch] = 1'b0;
            next_cur.mem_write         = 1'b1;
            next_cur.mem_channel       = ch;
            // separate buffer per channel, consecutive addresses
            next_cur.mem_addr = cur.base[ch*ADDR_WIDTH +: ADDR_WIDTH] + {8'h00, cur.count[ch*8 +: 8]};
            next_cur.mem_data = cur.pending[ch*ITEM_WIDTH +: ITEM_WIDTH];
            next_cur.count[ch*8 +: 8] = cur.count[ch*8 +: 8] + 8'd1;
            // the engine itself ends the block after 250 items
            if (cur.count[ch*8 +: 8] == BLOCK_ITEMS_W - 8'd1) begin
                next_cur.chan_enable[ch] = 1'b0;
            end
        end

        // software stop abandons the frame
        if (!cur.control[CTL_RUN_BIT] && cur.state == ACQ_RUN) begin
            next_cur.state       = ACQ_IDLE;
            next_cur.chan_enable = '0;
            next_cur.pulse       = 1'b0;
        end

        // register writes
        if (reg_write_i) begin
            if (reg_addr_i == REG_CONTROL) begin
                next_cur.control = reg_wdata_i[CTL_WIDTH-1:0];
            end else if (reg_addr_i == REG_STATUS) begin
                if (reg_wdata_i[STS_DONE_BIT]) begin
                    next_cur.done = 1'b0;
                end
            end else if (reg_addr_i == REG_FRAME_PERIOD) begin
                next_cur.frame_period = reg_wdata_i;
            end else if (reg_addr_i == REG_SAMPLE_PERIOD) begin
                next_cur.sample_period = reg_wdata_i[15:0];
            end else if (reg_addr_i[7:4] == REG_BASE_0[7:4]) begin
                next_cur.base[reg_chan(reg_addr_i)*ADDR_WIDTH +: ADDR_WIDTH] = reg_wdata_i[ADDR_WIDTH-1:0];
            end
        end
        // block completion wins over a clear in the same cycle
        if (cur.state == ACQ_RUN && cur.chan_enable == '0 && cur.pending_valid == '0) begin
            next_cur.done = 1'b1;
        end

        // register reads, answer in the following cycle
        if (reg_read_i) begin
            if (reg_addr_i == REG_CONTROL) begin
                next_cur.rdata = {27'h000_0000, cur.control};
            end else if (reg_addr_i == REG_STATUS) begin
                next_cur.rdata = {30'h0000_0000, cur.done, cur.state == ACQ_RUN};
            end else if (reg_addr_i == REG_FRAME_PERIOD) begin
                next_cur.rdata = cur.frame_period;
            end else if (reg_addr_i == REG_SAMPLE_PERIOD) begin
                next_cur.rdata = {16'h0000, cur.sample_period};
            end else if (reg_addr_i[7:4] == REG_BASE_0[7:4]) begin
                next_cur.rdata = {16'h0000, cur.base[reg_chan(reg_addr_i)*ADDR_WIDTH +: ADDR_WIDTH]};
            end else if (reg_addr_i[7:4] == REG_COUNT_0[7:4]) begin
                next_cur.rdata = {24'h00_0000, cur.count[reg_chan(reg_addr_i)*8 +: 8]};
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cur               <= '0;
            cur.state         <= ACQ_IDLE;
            cur.control       <= CTL_RESET;
            cur.frame_period  <= FRAME_PERIOD_RESET;
            cur.sample_period <= SAMPLE_PERIOD_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o             = cur.rdata;
    assign mem_write_o             = cur.mem_write;
    assign mem_channel_o           = cur.mem_channel;
    assign mem_addr_o              = cur.mem_addr;
    assign mem_data_o              = cur.mem_data;
    assign pulse_o                 = cur.pulse;
    assign transceiver_supply_en_o = cur.control[CTL_XCVR_BIT];
    assign divider_supply_en_o     = cur.control[CTL_DIV_BIT];
    assign transmit_power_en_o     = cur.control[CTL_TX_BIT];
    assign temp_reference_supply_o = cur.control[CTL_PTAT_BIT];

endmodule : radar_baseband_acquisition

// ===== bench/radar_acq_properties.sv
// radar_acq_properties: port-level timing checks of the capture block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module radar_acq_properties
    import radar_acq_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic mem_write_o,
    input wire logic [1:0] mem_channel_o,
    input wire logic [ADDR_WIDTH-1:0] mem_addr_o,
    input wire logic [ITEM_WIDTH-1:0] mem_data_o,
    input wire logic pulse_o,
    input wire logic transceiver_supply_en_o,
    input wire logic divider_supply_en_o,
    input wire logic transmit_power_en_o,
    input wire logic temp_reference_supply_o
);
    logic [4:0] seen;
    logic [1:0] quiet;
    logic [7:0] items [4];
    logic [ADDR_WIDTH-1:0] last_addr [4];
    // last control word, cycles since it, items per channel in this block
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            seen <= 5'h00;
            quiet <= 2'h3;
            for (int c = 0; c < 4; c++) begin
                items[c] <= 8'h00;
            end
        end else begin
            if (reg_write_i && reg_addr_i == REG_CONTROL) begin
                seen <= reg_wdata_i[4:0];
                quiet <= 2'h0;
            end else if (quiet != 2'h3) begin
                quiet <= quiet + 2'h1;
            end
            if (mem_write_o) begin
                items[mem_channel_o] <= (items[mem_channel_o] == 8'hf9) ? 8'h00 : items[mem_channel_o] + 8'h01;
                last_addr[mem_channel_o] <= mem_addr_o;
            end
        end
    end
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_quiet;
        !mem_write_o [*8];
    endsequence
    sequence s_tail;
        mem_write_o && mem_channel_o == 2'h1 ##1 mem_write_o && mem_channel_o == 2'h2
            ##1 mem_write_o && mem_channel_o == 2'h3;
    endsequence
    property p_xcvr;
        quiet == 2'h3 |-> transceiver_supply_en_o == seen[1];
    endproperty
    a_xcvr: assert property (p_xcvr) else $error("transceiver supply differs from control");
    property p_div;
        quiet == 2'h3 |-> divider_supply_en_o == seen[2];
    endproperty
    a_div: assert property (p_div) else $error("divider supply differs from control");
    property p_tx;
        quiet == 2'h3 |-> transmit_power_en_o == seen[3];
    endproperty
    a_tx: assert property (p_tx) else $error("transmit enable differs from control");
    property p_ref;
        quiet == 2'h3 |-> temp_reference_supply_o == seen[4];
    endproperty
    a_ref: assert property (p_ref) else $error("reference supply differs from control");
    property p_order;
        mem_write_o && mem_channel_o == 2'h0 |=> s_tail ##1 !mem_write_o;
    endproperty
    a_order: assert property (p_order) else $error("channel service order broken");
    property p_width;
        mem_write_o |-> mem_data_o[ITEM_WIDTH-1:SAMPLE_WIDTH] == 4'h0;
    endproperty
    a_width: assert property (p_width) else $error("item wider than converter result");
    property p_window;
        $rose(pulse_o) |-> s_quiet ##1 s_quiet ##[3:8] (mem_write_o && mem_channel_o == 2'h0);
    endproperty
    a_window: assert property (p_window) else $error("pass ignores sampling window");
    property p_stop;
        mem_write_o && mem_channel_o == 2'h3 && items[3] == 8'hf9 |=> ##[0:3] (!pulse_o && !mem_write_o) [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("pacing runs on after full block");
    property p_consec;
        mem_write_o && items[mem_channel_o] != 8'h00 |-> mem_addr_o == last_addr[mem_channel_o] + 16'h0001;
    endproperty
    a_consec: assert property (p_consec) else $error("item address not consecutive");
endmodule : radar_acq_properties

bind radar_baseband_acquisition radar_acq_properties u_props (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .mem_write_o, .mem_channel_o, .mem_addr_o, .mem_data_o, .pulse_o, .transceiver_supply_en_o,
    .divider_supply_en_o, .transmit_power_en_o, .temp_reference_supply_o);

// ===== bench/adc_memory_model.sv
// adc_memory_model: converter front end, one held result set per pacing pass
// assumes each rising pacing edge opens one pass of the capture block
`timescale 1ns/1ps
module adc_memory_model
(
    input  wire logic        clock_i,
    input  wire logic        pulse_i,
    input  wire logic [11:0] salt_i,
    output logic      [11:0] ch0_o = 12'h000,
    output logic      [11:0] ch1_o = 12'h000,
    output logic      [11:0] ch2_o = 12'h000,
    output logic      [11:0] ch3_o = 12'h000
);
    logic [11:0] pass_n = 12'h000;
    logic        pulse_d = 1'b0;
    // fresh distinct value per stream on each paced pass
    always @(posedge clock_i) begin
        pulse_d <= pulse_i;
        if (pulse_i && !pulse_d) begin
            ch0_o <= salt_i + pass_n * 12'h007;
            ch1_o <= salt_i + pass_n * 12'h007 + 12'h38f;
            ch2_o <= salt_i + pass_n * 12'h007 + 12'h71e;
            ch3_o <= salt_i + pass_n * 12'h007 + 12'haad;
            pass_n <= pass_n + 12'h001;
        end
    end
endmodule : adc_memory_model

// ===== bench/testbench.sv
// testbench: register setup, two full capture blocks, checks of every stored item
// assumes the converter model and the bound checker beside the block
`timescale 1ns/1ps
module testbench
    import radar_acq_pkg::*;
;
    logic clock_i = 1'b0, rst_n_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, d;
    logic [11:0] inphase_high_gain_i, quadrature_high_gain_i, inphase_low_gain_i, quadrature_low_gain_i, salt;
    logic mem_write_o, pulse_o, transceiver_supply_en_o, divider_supply_en_o, transmit_power_en_o;
    logic temp_reference_supply_o;
    logic [1:0] mem_channel_o;
    logic [15:0] mem_addr_o, mem_data_o, base [4];
    int errors = 0, compares = 0, seed = 24524, passes = 0, next_ch = 0, idx [4];
    radar_baseband_acquisition uut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
        .reg_rdata_o, .inphase_high_gain_i, .quadrature_high_gain_i, .inphase_low_gain_i, .quadrature_low_gain_i,
        .mem_write_o, .mem_channel_o, .mem_addr_o, .mem_data_o, .pulse_o, .transceiver_supply_en_o,
        .divider_supply_en_o, .transmit_power_en_o, .temp_reference_supply_o);
    adc_memory_model u_partner (.clock_i, .pulse_i(pulse_o), .salt_i(salt), .ch0_o(quadrature_high_gain_i),
        .ch1_o(inphase_high_gain_i), .ch2_o(quadrature_low_gain_i), .ch3_o(inphase_low_gain_i));
    // --------
    // helpers
    // --------
    function automatic logic [11:0] sample_of(input int n, input int ch);
        return salt + 12'(n * 7) + 12'(ch * 911);
    endfunction : sample_of
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask : reg_rd
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // clock
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    // every stored item against channel order, address and converter value
    always @(posedge clock_i) begin
        if (rst_n_i === 1'b1 && mem_write_o === 1'b1) begin
            check({30'h0, mem_channel_o}, next_ch, "channel");
            check({16'h0, mem_addr_o}, {16'h0, base[next_ch] + 16'(idx[next_ch])}, "address");
            check({16'h0, mem_data_o}, {20'h0, sample_of(passes, next_ch)}, "item");
            idx[next_ch]++;
            passes += (next_ch == 3) ? 1 : 0;
            next_ch = (next_ch + 1) % 4;
        end
    end
    // main sequence
    initial begin
        salt = 12'($random(seed));
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            reg_rd(8'(i * 4), d);
            check(d, i == 2 ? FRAME_PERIOD_RESET : i == 3 ? 32'(SAMPLE_PERIOD_RESET) : 32'h0, "reset");
        end
        for (int b = 1; b < 5; b++) begin
            reg_wr(REG_CONTROL, 32'h0000_0001 << b);
            repeat (3) @(posedge clock_i);
            #1;
            check({28'h0, temp_reference_supply_o, transmit_power_en_o, divider_supply_en_o,
                   transceiver_supply_en_o}, 32'h0000_0001 << (b - 1), "supplies");
        end
        reg_wr(8'h24, 32'h0000_00ff);
        reg_rd(8'h24, d);
        check(d, 32'h0000_0000, "read-only count");
        for (int blk = 0; blk < 2; blk++) begin
            for (int c = 0; c < 4; c++) begin
                base[c] = 16'($random(seed));
                idx[c] = 0;
                reg_wr(REG_BASE_0 + 8'(c * 4), {16'h0, base[c]});
            end
            reg_wr(REG_SAMPLE_PERIOD, 32'(26 + $unsigned($random(seed)) % 8));
            reg_wr(REG_FRAME_PERIOD, 32'h0000_4e20);
            reg_wr(REG_CONTROL, 32'h0000_001f);
            d = 32'h0000_0000;
            for (int k = 0; k < 25000 && d[1] !== 1'b1; k++) begin
                reg_rd(REG_STATUS, d);
            end
            if (d[1] !== 1'b1) begin
                errors++;
                $display("mismatch at %0t: block never completed", $time);
                conclude();
            end
            reg_wr(REG_CONTROL, 32'h0000_001e);
            for (int c = 0; c < 4; c++) begin
                reg_rd(REG_COUNT_0 + 8'(c * 4), d);
                check(d, 32'h0000_00fa, "count register");
                check(idx[c], 32'h0000_00fa, "items stored");
            end
            reg_wr(REG_STATUS, 32'h0000_0002);
            reg_rd(REG_STATUS, d);
            check(d, 32'h0000_0000, "status after stop");
        end
        conclude();
    end
endmodule : testbench
